// File: hw/ascore_top.v
// Serial transmit/receive core with transmit feed FIFO
`timescale 1ns/1ps
`default_nettype none
`include "ascore_defines.vh"

module ascore_fifo #(
  parameter W  = 8,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          in_valid,
  output reg           in_ready,
  input  wire [W-1:0]  in_data,
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data
);
  reg [W-1:0]  mem_q [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  reg [AW:0]   cnt_d;
  wire         push;
  wire         pop;
  integer      i;

  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];

  always @* begin
    cnt_d = cnt_q;
    if (push & ~pop) begin
      cnt_d = cnt_q + {{AW{1'b0}}, 1'b1};
    end else if (pop & ~push) begin
      cnt_d = cnt_q - {{AW{1'b0}}, 1'b1};
    end
  end

  // Ready is registered so the top port comes straight from a flop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q     <= {AW{1'b0}};
      rd_q     <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      for (i = 0; i < D; i = i + 1) begin
        mem_q[i] <= {W{1'b0}};
      end
    end else begin
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != D[AW:0]);
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q        <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // ascore_fifo

module ascore_top (
  input  wire        CLK,
  input  wire        RST,
  input  wire        TX_WRITE,
  input  wire [7:0]  TX_DATA,
  input  wire        TX_FIFO_VALID,
  input  wire [7:0]  TX_FIFO_DATA,
  output wire        TX_FIFO_READY,
  input  wire        CHAR_LEN_8,
  input  wire        STOP_TWO,
  input  wire        PARITY_SELECT_HI,
  input  wire        PARITY_SELECT_LO,
  input  wire        RX_ENABLE_BIT,
  input  wire        RXD,
  input  wire        RX_READ,
  output reg         TXD,
  output reg         TX_BUSY,
  output reg         TX_END_IRQ,
  output reg         RX_END_IRQ,
  output reg         RX_ERROR_IRQ,
  output reg  [7:0]  RX_HOLDING_BUFFER,
  output reg  [7:0]  RX_ERROR_STATUS_REG,
  output reg  [15:0] RX_END_VECTOR,
  output reg  [15:0] RX_ERROR_VECTOR
);
  localparam S_IDLE  = 5'b00001;
  localparam S_START = 5'b00010;
  localparam S_DATA  = 5'b00100;
  localparam S_PAR   = 5'b01000;
  localparam S_STOP  = 5'b10000;

  // Parity bit for a character under the selected mode
  function par_bit;
    input [7:0] d;
    input       cl8;
    input [1:0] ps;
    reg         x;
    begin
      x = ^{d[7] & cl8, d[6:0]};
      case (ps)
        `ASC_PS_ODD:  par_bit = ~x;
        `ASC_PS_EVEN: par_bit = x;
        default:      par_bit = 1'b0;
      endcase
    end
  endfunction

  wire [1:0] ps      = {PARITY_SELECT_HI, PARITY_SELECT_LO};
  wire       par_on  = (ps != `ASC_PS_NONE);
  wire [2:0] bit_last = CHAR_LEN_8 ? `ASC_BITS_8_LAST : `ASC_BITS_7_LAST;

  // Transmitter
  reg  [4:0] tx_st_q;
  reg  [3:0] tx_cnt_q;
  reg  [2:0] tx_bit_q;
  reg  [7:0] tx_shift_reg_q;
  reg        tx_par_q;
  reg        tx_stop2_q;
  wire       tx_idle   = tx_st_q[0];
  wire       tx_tick   = (tx_cnt_q == `ASC_TICK_LAST);
  wire       fifo_valid;
  wire [7:0] fifo_data;
  // Direct write takes priority; the FIFO stalls while a frame is out
  wire       fifo_pop  = tx_idle & ~TX_WRITE;
  wire       tx_load   = tx_idle & (TX_WRITE | fifo_valid);
  wire [7:0] tx_byte   = TX_WRITE ? TX_DATA : fifo_data;

  ascore_fifo #(
    .W  (8),
    .D  (8),
    .AW (3)
  ) u_fifo (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (TX_FIFO_VALID),
    .in_ready  (TX_FIFO_READY),
    .in_data   (TX_FIFO_DATA),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      tx_st_q        <= S_IDLE;
      tx_cnt_q       <= 4'h0;
      tx_bit_q       <= 3'h0;
      tx_shift_reg_q <= `ASC_BYTE_ZERO;
      tx_par_q       <= 1'b0;
      tx_stop2_q     <= 1'b0;
      TXD            <= 1'b1;
      TX_BUSY        <= 1'b0;
      TX_END_IRQ     <= 1'b0;
    end else begin
      TX_END_IRQ <= 1'b0;
      tx_cnt_q   <= tx_idle ? 4'h0 : tx_cnt_q + `ASC_TICK_ONE;
      case (tx_st_q)
        S_IDLE: begin
          if (tx_load) begin
            tx_shift_reg_q <= tx_byte;
            tx_par_q       <= par_bit(tx_byte, CHAR_LEN_8, ps);
            tx_bit_q       <= 3'h0;
            tx_stop2_q     <= 1'b0;
            tx_st_q        <= S_START;
          end
        end
        S_START: begin
          if (tx_tick) begin
            tx_st_q <= S_DATA;
          end
        end
        S_DATA: begin
          // Writes are not looked at outside idle, so the frame is safe
          if (tx_tick) begin
            tx_shift_reg_q <= {1'b0, tx_shift_reg_q[7:1]};
            tx_bit_q       <= tx_bit_q + 3'h1;
            if (tx_bit_q == bit_last) begin
              tx_st_q <= par_on ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR: begin
          if (tx_tick) begin
            tx_st_q <= S_STOP;
          end
        end
        S_STOP: begin
          if (tx_tick) begin
            if (STOP_TWO & ~tx_stop2_q) begin
              tx_stop2_q <= 1'b1;
            end else begin
              tx_st_q    <= S_IDLE;
              TX_END_IRQ <= 1'b1;
            end
          end
        end
        default: tx_st_q <= S_IDLE;
      endcase
      // Line level lags the state by one cycle uniformly
      case (tx_st_q)
        S_START: TXD <= 1'b0;
        S_DATA:  TXD <= tx_shift_reg_q[0];
        S_PAR:   TXD <= tx_par_q;
        default: TXD <= 1'b1;
      endcase
      TX_BUSY <= ~tx_idle | tx_load;
    end
  end

  // Receiver
  reg        rxd_m_q;
  reg        rxd_s_q;
  reg  [4:0] rx_st_q;
  reg  [3:0] rx_cnt_q;
  reg  [2:0] rx_bit_q;
  reg  [7:0] rx_sh_q;
  reg        rx_par_q;
  reg        rx_unread_q;
  wire       rx_tick = (rx_cnt_q == `ASC_TICK_LAST);
  wire       rx_done = rx_st_q[4] & rx_tick & RX_ENABLE_BIT;
  wire       pe      = (ps != `ASC_PS_NONE) & (ps != `ASC_PS_ZERO) &
                       (rx_par_q != par_bit(rx_sh_q, CHAR_LEN_8, ps));
  wire       fe      = ~rxd_s_q;
  wire       ovr     = rx_unread_q;

  // Two flops before the line is looked at; only the second is used
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end else begin
      rxd_m_q <= RXD;
      rxd_s_q <= rxd_m_q;
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_st_q             <= S_IDLE;
      rx_cnt_q            <= 4'h0;
      rx_bit_q            <= 3'h0;
      rx_sh_q             <= `ASC_BYTE_ZERO;
      rx_par_q            <= 1'b0;
      rx_unread_q         <= 1'b0;
      RX_HOLDING_BUFFER   <= `ASC_BYTE_ZERO;
      RX_ERROR_STATUS_REG <= `ASC_BYTE_ZERO;
      RX_END_IRQ          <= 1'b0;
      RX_ERROR_IRQ        <= 1'b0;
      RX_END_VECTOR       <= `ASC_VEC_ZERO;
      RX_ERROR_VECTOR     <= `ASC_VEC_ZERO;
    end else begin
      RX_END_VECTOR   <= `ASC_VEC_RX_END;
      RX_ERROR_VECTOR <= `ASC_VEC_RX_ERR;
      RX_END_IRQ      <= 1'b0;
      RX_ERROR_IRQ    <= 1'b0;
      rx_cnt_q        <= rx_cnt_q + `ASC_TICK_ONE;
      if (~RX_ENABLE_BIT) begin
        rx_st_q <= S_IDLE;
      end else begin
        case (rx_st_q)
          S_IDLE: begin
            rx_cnt_q <= 4'h0;
            if (~rxd_s_q) begin
              rx_st_q <= S_START;
            end
          end
          S_START: begin
            if (rx_cnt_q == `ASC_TICK_HALF) begin
              rx_cnt_q <= 4'h0;
              rx_bit_q <= 3'h0;
              rx_sh_q  <= `ASC_BYTE_ZERO;
              rx_st_q  <= rxd_s_q ? S_IDLE : S_DATA;
            end
          end
          S_DATA: begin
            if (rx_tick) begin
              rx_sh_q[rx_bit_q] <= rxd_s_q;
              rx_bit_q          <= rx_bit_q + 3'h1;
              if (rx_bit_q == bit_last) begin
                rx_st_q <= par_on ? S_PAR : S_STOP;
              end
            end
          end
          S_PAR: begin
            if (rx_tick) begin
              rx_par_q <= rxd_s_q;
              rx_st_q  <= S_STOP;
            end
          end
          S_STOP: begin
            // Only one stop bit is checked, so a second gives resync slack
            if (rx_tick) begin
              rx_st_q <= S_IDLE;
            end
          end
          default: rx_st_q <= S_IDLE;
        endcase
      end
      if (rx_done) begin
        RX_HOLDING_BUFFER   <= rx_sh_q;
        RX_END_IRQ          <= 1'b1;
        RX_ERROR_IRQ        <= pe | fe | ovr;
        RX_ERROR_STATUS_REG <= {`ASC_ST_ZERO, pe, fe, ovr};
        rx_unread_q         <= 1'b1;
      end else if (RX_READ) begin
        RX_ERROR_STATUS_REG <= `ASC_BYTE_ZERO;
        rx_unread_q         <= 1'b0;
      end
    end
  end
endmodule // ascore_top
`default_nettype wire

// File: shared/ascore_defines.vh
// Constants for the asynchronous serial transmit/receive core
`ifndef ASCORE_DEFINES_VH
`define ASCORE_DEFINES_VH
`define ASC_TICK_LAST   4'hF
`define ASC_TICK_HALF   4'h7
`define ASC_TICK_ONE    4'h1
`define ASC_BITS_8_LAST 3'h7
`define ASC_BITS_7_LAST 3'h6
`define ASC_PS_NONE     2'h0
`define ASC_PS_ZERO     2'h1
`define ASC_PS_ODD      2'h2
`define ASC_PS_EVEN     2'h3
`define ASC_ST_OVR      0
`define ASC_ST_FRM      1
`define ASC_ST_PAR      2
`define ASC_ST_ZERO     5'h00
`define ASC_VEC_RX_END  16'h001E
`define ASC_VEC_RX_ERR  16'h001C
`define ASC_BYTE_ZERO   8'h00
`define ASC_VEC_ZERO    16'h0000
`endif

// File: tb/ascore_chk.sv
// Port-level assertions for the serial transmit/receive core
`timescale 1ns/1ps
`default_nettype none
module ascore_chk (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        RX_ENABLE_BIT,
  input wire logic        RX_READ,
  input wire logic        TXD,
  input wire logic        TX_BUSY,
  input wire logic        TX_END_IRQ,
  input wire logic        RX_END_IRQ,
  input wire logic        RX_ERROR_IRQ,
  input wire logic [7:0]  RX_HOLDING_BUFFER,
  input wire logic [7:0]  RX_ERROR_STATUS_REG,
  input wire logic [15:0] RX_END_VECTOR,
  input wire logic [15:0] RX_ERROR_VECTOR
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RST);
  property p_start; $rose(TX_BUSY) |=> (!TXD) [*8]; endproperty
  a_start: assert property (p_start) else $error("start bit missing");
  property p_tend; TX_END_IRQ |-> TXD ##1 !TX_END_IRQ; endproperty
  a_tend: assert property (p_tend) else $error("tx end pulse bad");
  // The edge just after reset must not see a stale end pulse
  property p_rst; $past(RST) |-> !TX_END_IRQ; endproperty
  a_rst: assert property (p_rst) else $error("tx end after reset");
  property p_vec; !$past(RST) |-> RX_END_VECTOR == 16'h001E && RX_ERROR_VECTOR == 16'h001C; endproperty
  a_vec: assert property (p_vec) else $error("vector entry bad");
  property p_hi; RX_ERROR_STATUS_REG[7:3] == 5'h00; endproperty
  a_hi: assert property (p_hi) else $error("status high bits set");
  property p_flag; RX_END_IRQ |-> RX_ERROR_IRQ == (RX_ERROR_STATUS_REG[2:0] != 3'h0); endproperty
  a_flag: assert property (p_flag) else $error("error pulse vs flags");
  property p_abort; !RX_ENABLE_BIT |=> !RX_END_IRQ && $stable(RX_HOLDING_BUFFER); endproperty
  a_abort: assert property (p_abort) else $error("receive while disabled");
  property p_rdclr; $past(RX_READ) && !RX_END_IRQ |-> RX_ERROR_STATUS_REG[2:0] == 3'h0; endproperty
  a_rdclr: assert property (p_rdclr) else $error("read left flags");
endmodule // ascore_chk
bind ascore_top ascore_chk u_chk (
  .CLK, .RST, .RX_ENABLE_BIT, .RX_READ, .TXD, .TX_BUSY, .TX_END_IRQ, .RX_END_IRQ,
  .RX_ERROR_IRQ, .RX_HOLDING_BUFFER, .RX_ERROR_STATUS_REG, .RX_END_VECTOR, .RX_ERROR_VECTOR
);
`default_nettype wire

// File: tb/ascore_remote.sv
// Remote serial transceiver on the far end of the line
`timescale 1ns/1ps
`default_nettype none
module ascore_remote (
  input  wire logic        clk,
  input  wire logic        txd,
  input  wire logic [3:0]  nbits,
  output var  logic        rxd,
  output var  logic [11:0] got,
  output var  int          frames
);
  initial begin
    rxd = 1'b1;
    frames = 0;
  end
  // Bits leave LSB first; line goes back high after the frame
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd = f[i];
      repeat (16) @(negedge clk);
    end
    rxd = 1'b1;
  endtask
  // Centre sampling; stops after nbits so a back-to-back start is not missed
  always begin
    @(negedge txd);
    got = 12'hFFF;
    repeat (8) @(negedge clk);
    got[0] = txd;
    for (int i = 1; i < nbits; i++) begin
      repeat (16) @(negedge clk);
      got[i] = txd;
    end
    frames++;
  end
endmodule // ascore_remote
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the serial transmit/receive core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rst, txw, fv, c8, s2, psh, psl, rx_enable_bit, rdp;
  logic [7:0]  txdat, fdat, rbuf, stat;
  logic [3:0]  nb;
  logic        txd, busy, te, re, ree, frdy, rxd;
  logic [11:0] got;
  int          frames, miscompares, num_checks;
  ascore_top DUT (
    .CLK(clk), .RST(rst), .TX_WRITE(txw), .TX_DATA(txdat), .TX_FIFO_VALID(fv), .TX_FIFO_DATA(fdat),
    .TX_FIFO_READY(frdy), .CHAR_LEN_8(c8), .STOP_TWO(s2), .PARITY_SELECT_HI(psh), .PARITY_SELECT_LO(psl),
    .RX_ENABLE_BIT(rx_enable_bit), .RXD(rxd), .RX_READ(rdp), .TXD(txd), .TX_BUSY(busy), .TX_END_IRQ(te),
    .RX_END_IRQ(re), .RX_ERROR_IRQ(ree), .RX_HOLDING_BUFFER(rbuf), .RX_ERROR_STATUS_REG(stat),
    .RX_END_VECTOR(), .RX_ERROR_VECTOR()
  );
  ascore_remote rem (.clk(clk), .txd(txd), .nbits(nb), .rxd(rxd), .got(got), .frames(frames));
  task automatic chk(input string nm, input logic [15:0] e, v);
    num_checks++;
    if (v !== e) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", nm, e, v);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Bounded wait for transmit end (sel 0) or receive end (sel 1)
  task automatic wt(input bit sel, input int lim, output int k);
    k = 0;
    while ((sel ? re : te) !== 1'b1) begin
      @(negedge clk);
      k++;
      if (k > lim) begin
        miscompares++;
        finish_test;
      end
    end
  endtask
  // Whole frame as sent on the line, start bit at index 0
  function automatic logic [11:0] mkf(input logic [7:0] d, input logic l8, input logic [1:0] p);
    logic [11:0] f;
    logic        x;
    f = 12'hFFF;
    f[7:0] = {d[6:0], 1'b0};
    f[8] = l8 ? d[7] : 1'b1;
    x = ^(d & {l8, 7'h7F});
    if (p != 2'h0)
      f[8 + l8] = p[1] & (x ^ ~p[0]);
    return f;
  endfunction
  task automatic rd;
    @(negedge clk);
    rdp = 1'b1;
    @(negedge clk);
    rdp = 1'b0;
  endtask
  task automatic t_reset;
    repeat (6) @(negedge clk);
    chk("txd_idle", 1, txd);
    chk("status", 0, stat);
    chk("fifo_ready", 1, frdy);
    rst = 1'b0;
  endtask
  // Write is held high well into the frame: the repeats must be ignored
  task automatic t_tx(input logic l8, t2, input logic [1:0] p, input logic [7:0] d);
    int k;
    int n;
    n = 9 + l8 + t2 + (p != 2'h0);
    {c8, s2, psh, psl} = {l8, t2, p};
    nb = n[3:0];
    txdat = d;
    txw = 1'b1;
    @(negedge clk);
    txdat = ~d;
    repeat (40) @(negedge clk);
    txw = 1'b0;
    wt(0, 16 * n, k);
    // End edge lies n bit times (16 * n clocks) past the load edge and is seen one negedge later
    chk("tx_end_time", 16 * n + 1, 41 + k);
    chk("tx_frame", mkf(d, l8, p), got);
  endtask
  task automatic t_fifo;
    int k;
    int c;
    repeat (40) @(negedge clk);
    chk("tx_idle", 1, txd);
    chk("frames", 4, frames);
    {c8, s2, psh, psl} = 4'h8;
    nb = 4'hA;
    k = 0;
    while (frdy === 1'b1 && k < 12) begin
      fdat = 8'h30 + k[7:0];
      fv = 1'b1;
      k++;
      @(negedge clk);
    end
    fdat = 8'hEE;
    @(negedge clk);
    fv = 1'b0;
    chk("fifo_fill", 9, k);
    for (int i = 0; i < 9; i++) begin
      wt(0, 400, c);
      chk("fifo_word", mkf(8'h30 + i[7:0], 1'b1, 2'h0), got);
      @(negedge clk);
    end
    chk("fifo_ready", 1, frdy);
  endtask
  // Reset in mid-frame empties the transmitter and must not count as a frame end
  task automatic t_tx_reset;
    int k;
    int hits;
    hits = 0;
    {c8, s2, psh, psl} = 4'h8;
    nb = 4'hA;
    txdat = 8'h96;
    txw = 1'b1;
    @(negedge clk);
    txw = 1'b0;
    repeat (50) @(negedge clk);
    chk("tx_busy", 1, busy);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk("tx_busy_rst", 0, busy);
    rst = 1'b0;
    for (k = 0; k < 200; k++) begin
      if (te !== 1'b0)
        hits++;
      @(negedge clk);
    end
    chk("tx_end_rst", 0, hits);
    chk("txd_rst", 1, txd);
  endtask
  task automatic t_rx(input logic [11:0] f, input int n, input logic [7:0] eb, input logic [2:0] es);
    int k;
    fork
      rem.send(f, n);
      begin
        wt(1, 16 * n + 40, k);
        chk("rx_error_irq", es != 3'h0, ree);
      end
    join
    chk("rx_buffer", eb, rbuf);
    chk("rx_status", es, stat);
  endtask
  task automatic t_rx_err;
    rx_enable_bit = 1'b1;
    {c8, s2, psh, psl} = 4'h8;
    t_rx(mkf(8'hA5, 1'b1, 2'h0), 10, 8'hA5, 3'h0);
    rd;
    {psh, psl} = 2'h3;
    t_rx(mkf(8'h5A, 1'b1, 2'h3) ^ 12'h200, 11, 8'h5A, 3'h4);
    rd;
    chk("status_read", 0, stat);
    {psh, psl} = 2'h0;
    t_rx(mkf(8'hC3, 1'b1, 2'h0) ^ 12'h200, 10, 8'hC3, 3'h2);
    t_rx(mkf(8'h11, 1'b1, 2'h0), 10, 8'h11, 3'h1);
    t_rx(mkf(8'h22, 1'b1, 2'h0), 10, 8'h22, 3'h1);
    rd;
    {c8, psh, psl} = 3'h1;
    t_rx(mkf(8'h7F, 1'b0, 2'h1) | 12'h100, 10, 8'h7F, 3'h0);
  endtask
  task automatic t_rx_abort;
    rd;
    {c8, psh, psl} = 3'h4;
    fork
      rem.send(mkf(8'h99, 1'b1, 2'h0), 10);
      begin
        repeat (60) @(negedge clk);
        rx_enable_bit = 1'b0;
      end
    join
    rem.send(mkf(8'h66, 1'b1, 2'h0), 10);
    chk("rx_buffer_kept", 8'h7F, rbuf);
    rx_enable_bit = 1'b1;
    t_rx(mkf(8'h3C, 1'b1, 2'h0), 10, 8'h3C, 3'h0);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rst, txw, fv, c8, s2, psh, psl, rx_enable_bit, rdp} = 9'h100;
    txdat = 8'h00;
    fdat = 8'h00;
    nb = 4'hA;
    t_reset;
    t_tx(1'b1, 1'b0, 2'h0, 8'hA5);
    t_tx(1'b0, 1'b1, 2'h3, 8'h5B);
    t_tx(1'b1, 1'b0, 2'h2, 8'h3C);
    t_tx(1'b0, 1'b0, 2'h1, 8'h7F);
    t_fifo;
    t_tx_reset;
    t_rx_err;
    t_rx_abort;
    finish_test;
  end
endmodule // testbench
`default_nettype wire
